/* File: chain_flag_bank.sv */
module chain_flag_bank
(
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         nrst_in,
   // flag traffic
   chain_status_if.owner     bus
);

   logic [3:0] flag_r;

   // ----------------------------------------
   // sticky flags, one per channel
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < chain_status_pkg::NUM_CHAN; g++)
      begin : g_flag
         always_ff @(posedge mclk_in or negedge nrst_in)
         begin
            if (!nrst_in)
               flag_r[g] <= chain_status_pkg::FLAGS_RESET[g];
            // set wins over a clear in the same cycle
            else if (bus.done_in[g])
               flag_r[g] <= 1'b1;
            else if (bus.clear_mask[g])
               flag_r[g] <= 1'b0;
         end
      end
   endgenerate

   assign bus.flags = flag_r;

   chk_set_wins_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (bus.done_in[0] && bus.clear_mask[0]) |=> flag_r[0])
      else $error("completion lost to a same-cycle clear");

   chk_clear_only_one: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (bus.clear_mask == 4'h1 && bus.done_in == 4'h0) |=> (flag_r[3:1] == $past(flag_r[3:1])))
      else $error("clearing one flag disturbed another");

endmodule : chain_flag_bank

/* File: chain_status_if.sv */
interface chain_status_if;
   logic [3:0] done_in;
   logic [3:0] clear_mask;
   logic [3:0] flags;

   modport owner (input done_in, input clear_mask, output flags);
   modport user  (output done_in, output clear_mask, input flags);
endinterface : chain_status_if

/* File: chain_status_pkg.sv */
package chain_status_pkg;
   // ----------------------------------------
   // register offsets (byte register space)
   // ----------------------------------------
   localparam logic [11:0] CHAIN_CONTROL_OFS  = 12'hd98;
   localparam logic [11:0] CHAIN_STATUS_OFS   = 12'hd99;
   localparam logic [11:0] CHAIN_IRQ_EN_OFS   = 12'hd9a;
   localparam logic [11:0] CHAIN_VALID_OFS    = 12'hd9b;
   localparam logic [11:0] MODE_CONTROL_OFS   = 12'hd9c;

   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int          NUM_CHAN           = 4;
   localparam int          CH3_BIT            = 0;
   localparam int          CH5_BIT            = 1;
   localparam int          CH6_BIT            = 2;
   localparam int          CH7_BIT            = 3;
   localparam int          EXT_MODE_BIT       = 0;
   localparam logic [3:0]  FLAGS_RESET        = 4'h0;
   localparam logic [3:0]  ENABLES_RESET      = 4'h0;
   localparam logic [7:0]  READ_RESET         = 8'h00;
endpackage : chain_status_pkg

/* File: dma_chain_buffer_status.sv */
// What this block does
// - completion on channel 7,6,5,3 sets status bit 3,2,1,0
// - set flag with its enable raised requests the chaining interrupt
// - writing one to a set flag clears it and drops its request
// - writing zero to a flag leaves it unchanged
// - writing one to a clear flag does nothing
// - flag read value only meaningful while chaining is enabled for the channel
// - one shared interrupt output for channels 3, 5, 6 and 7
// - clearing one flag leaves the others and their requests intact
// - per-channel chaining enables act only in extended mode
// - per-channel interrupt enable, effective only while chaining is on
// - end of buffer at count zero; reload and clear valid if set
module dma_chain_buffer_status
(
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         nrst_in,
   // register access
   input  wire logic [11:0]  reg_addr_in,
   input  wire logic         reg_wr_in,
   input  wire logic         reg_rd_in,
   input  wire logic [7:0]   reg_wdata_in,
   output logic      [7:0]   reg_rdata_out,
   // channel datapath events, channels 7,6,5,3 at bits 3..0
   input  wire logic [3:0]   count_zero_in,
   output logic      [3:0]   reload_out,
   output logic      [3:0]   chain_active_out,
   // interrupt
   output logic              chain_irq_out
);

   logic [3:0] chain_en_r;
   logic [3:0] irq_en_r;
   logic [3:0] valid_r;
   logic       ext_mode_r;
   logic [3:0] active;
   logic [3:0] done_ev;
   logic [3:0] reload_nxt;
   logic [3:0] wr_clear;
   logic [7:0] rdata_nxt;
   logic       irq_nxt;

   chain_status_if st ();

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         chain_en_r <= chain_status_pkg::ENABLES_RESET;
      else if (reg_wr_in && reg_addr_in == chain_status_pkg::CHAIN_CONTROL_OFS)
         chain_en_r <= reg_wdata_in[3:0];
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         irq_en_r <= chain_status_pkg::ENABLES_RESET;
      else if (reg_wr_in && reg_addr_in == chain_status_pkg::CHAIN_IRQ_EN_OFS)
         irq_en_r <= reg_wdata_in[3:0];
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         ext_mode_r <= 1'b0;
      else if (reg_wr_in && reg_addr_in == chain_status_pkg::MODE_CONTROL_OFS)
         ext_mode_r <= reg_wdata_in[chain_status_pkg::EXT_MODE_BIT];
   end

   // chaining control bits are ignored outside extended mode
   assign active = ext_mode_r ? chain_en_r : 4'h0;

   // ----------------------------------------
   // end of buffer and next-buffer valid
   // ----------------------------------------
   // only chained channels report; others end with terminal count elsewhere
   assign done_ev    = count_zero_in & active;
   assign reload_nxt = done_ev & valid_r;

   // hardware clear wins so a consumed buffer is never reused
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         valid_r <= chain_status_pkg::FLAGS_RESET;
      else if (reg_wr_in && reg_addr_in == chain_status_pkg::CHAIN_VALID_OFS)
         valid_r <= (valid_r | reg_wdata_in[3:0]) & ~reload_nxt;
      else
         valid_r <= valid_r & ~reload_nxt;
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         reload_out <= 4'h0;
      else
         reload_out <= reload_nxt;
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         chain_active_out <= 4'h0;
      else
         chain_active_out <= active;
   end

   // ----------------------------------------
   // status flags (write one to clear)
   // ----------------------------------------
   // reserved bits 7..4 are dropped; zeros leave flags alone
   assign wr_clear = (reg_wr_in && reg_addr_in == chain_status_pkg::CHAIN_STATUS_OFS)
                     ? reg_wdata_in[3:0] : 4'h0;

   assign st.done_in    = done_ev;
   assign st.clear_mask = wr_clear;

   chain_flag_bank u_flags
   (
      .mclk_in (mclk_in),
      .nrst_in (nrst_in),
      .bus     (st)
   );

   // ----------------------------------------
   // shared interrupt
   // ----------------------------------------
   // enable matters only while chaining is on for the channel
   assign irq_nxt = |(st.flags & irq_en_r & active);

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         chain_irq_out <= 1'b0;
      else
         chain_irq_out <= irq_nxt;
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb
   begin
      rdata_nxt = chain_status_pkg::READ_RESET;
      case (reg_addr_in)
         chain_status_pkg::CHAIN_CONTROL_OFS: rdata_nxt = {4'h0, chain_en_r};
         chain_status_pkg::CHAIN_STATUS_OFS:  rdata_nxt = {4'h0, st.flags};
         chain_status_pkg::CHAIN_IRQ_EN_OFS:  rdata_nxt = {4'h0, irq_en_r};
         chain_status_pkg::CHAIN_VALID_OFS:   rdata_nxt = {4'h0, valid_r};
         chain_status_pkg::MODE_CONTROL_OFS:  rdata_nxt = {7'h00, ext_mode_r};
         default:                             rdata_nxt = chain_status_pkg::READ_RESET;
      endcase
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         reg_rdata_out <= chain_status_pkg::READ_RESET;
      else if (reg_rd_in)
         reg_rdata_out <= rdata_nxt;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_flag_sets: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      done_ev[3] |=> st.flags[3])
      else $error("channel 7 completion did not set its flag");

   chk_irq_follows: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (st.flags[0] && irq_en_r[0] && active[0]) |=> chain_irq_out)
      else $error("enabled flag did not raise interrupt");

   chk_w1c_clears: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (wr_clear[1] && !done_ev[1]) |=> !st.flags[1] ##1 (!chain_irq_out || $past(st.flags) != 4'h0))
      else $error("write one did not clear the flag");

   chk_zero_keeps: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (reg_wr_in && reg_addr_in == chain_status_pkg::CHAIN_STATUS_OFS && !reg_wdata_in[2] && st.flags[2])
      |=> st.flags[2])
      else $error("writing zero changed a flag");

   chk_clear_noset: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (wr_clear[3] && !st.flags[3] && !done_ev[3]) |=> !st.flags[3])
      else $error("write one set a clear flag");

   chk_irq_masked: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      ((st.flags & irq_en_r & active) == 4'h0) |=> !chain_irq_out)
      else $error("interrupt without an enabled flag");

   chk_mode_gates: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !ext_mode_r |-> (done_ev == 4'h0))
      else $error("chaining acted outside extended mode");

   chk_valid_drop: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      reload_nxt[2] |=> (reload_out[2] && !valid_r[2]))
      else $error("reload did not clear next-buffer valid");

   // enables cannot move in the clearing cycle, a status write owns the bus then
   chk_others_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (wr_clear != 4'h0 && (st.flags & ~wr_clear & irq_en_r & active) != 4'h0) |=> ##1 chain_irq_out)
      else $error("acknowledge dropped another pending interrupt");

   chk_reload_pulse: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      reload_out[0] |=> !reload_out[0])
      else $error("reload repeated without a fresh valid");

   chk_valid_keep: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (valid_r[0] && !reload_nxt[0]) |=> valid_r[0])
      else $error("next-buffer valid lost without a reload");

   chk_idle_noset: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (!active[1] && !st.flags[1]) |=> !st.flags[1])
      else $error("inactive channel set its flag");

   chk_mode_outputs: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !ext_mode_r |=> (chain_active_out == 4'h0 && reload_out == 4'h0))
      else $error("chaining outputs moved outside extended mode");

   chk_irq_en_gate: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (irq_en_r == 4'h0) |=> !chain_irq_out)
      else $error("interrupt with every enable low");

   chk_status_read: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == chain_status_pkg::CHAIN_STATUS_OFS) |=> (reg_rdata_out == {4'h0, $past(st.flags)}))
      else $error("status read did not return the flags");

endmodule : dma_chain_buffer_status

/* File: dma_chain_buffer_status_bench.sv */
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("unexpected %0t got %h want %h", $time, g, e); end end
module dma_chain_buffer_status_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CT = chain_status_pkg::CHAIN_CONTROL_OFS;
   localparam logic [11:0] ST = chain_status_pkg::CHAIN_STATUS_OFS;
   localparam logic [11:0] IE = chain_status_pkg::CHAIN_IRQ_EN_OFS;
   localparam logic [11:0] VL = chain_status_pkg::CHAIN_VALID_OFS;
   localparam logic [11:0] MD = chain_status_pkg::MODE_CONTROL_OFS;
   logic        mclk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0, chain_irq_out, mode = 0;
   logic [11:0] reg_addr_in = 12'h000;
   logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out;
   logic [3:0]  count_zero_in = 4'h0, reload_out, chain_active_out;
   logic [3:0]  flags = 4'h0, en = 4'h0, ctl = 4'h0, valid = 4'h0, act, rl;
   int          miscompares = 0, n_tests = 0, cyc = 0;

   dma_chain_buffer_status dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .count_zero_in(count_zero_in), .reload_out(reload_out),
      .chain_active_out(chain_active_out), .chain_irq_out(chain_irq_out));

   initial
   begin
      forever #10 mclk_in = ~mclk_in;
   end

   // ----------------------------------------
   // model and bus steps
   // ----------------------------------------
   function logic [7:0] exp_rd(input logic [11:0] a);
      case (a)
         CT: exp_rd = {4'h0, ctl};
         ST: exp_rd = {4'h0, flags & act};
         IE: exp_rd = {4'h0, en};
         VL: exp_rd = {4'h0, valid};
         MD: exp_rd = {7'h00, mode};
         default: exp_rd = 8'h00;
      endcase
   endfunction

   // one event and/or write cycle; set beats clear on a shared edge
   task step(input logic [3:0] cz, input logic wr, input logic [11:0] a, input logic [7:0] wd);
      @(negedge mclk_in);
      count_zero_in = cz;
      reg_wr_in = wr;
      reg_addr_in = a;
      reg_wdata_in = wd;
      act = ctl & {4{mode}};
      rl = cz & act & valid;
      flags = (flags & ~((wr && a == ST) ? wd[3:0] : 4'h0)) | (cz & act);
      valid = (valid | ((wr && a == VL) ? wd[3:0] : 4'h0)) & ~rl;
      if (wr && a == CT)
         ctl = wd[3:0];
      if (wr && a == IE)
         en = wd[3:0];
      if (wr && a == MD)
         mode = wd[chain_status_pkg::EXT_MODE_BIT];
      @(negedge mclk_in);
      count_zero_in = 4'h0;
      reg_wr_in = 1'b0;
      `CHK(reload_out, rl)
   endtask

   // status bits compared only where chaining is live
   task rd(input logic [11:0] a);
      @(negedge mclk_in);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(negedge mclk_in);
      reg_rd_in = 1'b0;
      act = ctl & {4{mode}};
      `CHK(reg_rdata_out & ((a == ST) ? {4'h0, act} : 8'hff), exp_rd(a))
      `CHK(chain_irq_out, |(flags & en & act))
      `CHK(chain_active_out, act)
   endtask

   task finish_test;
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         miscompares++;
         finish_test;
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      logic [11:0] a;
      void'($urandom(32'h50e7));
      repeat (20) @(posedge mclk_in);
      @(negedge mclk_in);
      nrst_in = 1'b1;
      for (int i = 0; i < 6; i++)
         rd(CT + 12'(i));
      step(4'hf, 1'b0, ST, 8'h00);
      rd(ST);
      step(4'h0, 1'b1, MD, 8'h01);
      step(4'h0, 1'b1, CT, 8'h0f);
      step(4'h0, 1'b1, IE, 8'h0f);
      step(4'h0, 1'b1, VL, 8'h05);
      step(4'hf, 1'b0, ST, 8'h00);
      step(4'h0, 1'b1, ST, 8'h00);
      rd(ST);
      step(4'h0, 1'b1, ST, 8'h01);
      rd(ST);
      step(4'h1, 1'b1, ST, 8'h03);
      rd(ST);
      step(4'h0, 1'b1, ST, 8'h02);
      rd(ST);
      step(4'h0, 1'b1, ST, 8'h0d);
      rd(ST);
      // reset in mid-run with flags and enables live
      step(4'hf, 1'b0, ST, 8'h00);
      @(negedge mclk_in);
      nrst_in = 1'b0;
      {flags, en, ctl, valid, mode} = 17'h0;
      repeat (3) @(negedge mclk_in);
      nrst_in = 1'b1;
      for (int i = 0; i < 6; i++)
         rd(CT + 12'(i));
      for (int i = 0; i < 400; i++)
      begin
         a = CT + 12'($urandom % 6);
         step(4'($urandom), 1'($urandom), a, {4'h0, 4'($urandom)});
         rd(CT + 12'($urandom % 6));
      end
      finish_test;
   end
endmodule // dma_chain_buffer_status_bench
